// >>> bench/frpe_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ==============================================================
// Port checker for the row program and erase controller
// ==============================================================
module frpe_ctrl_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Core low-power modes
    input wire logic wait_mode,
    input wire logic stop_mode,
    // Array control
    input wire logic arr_program,
    input wire logic arr_erase,
    input wire logic arr_latch,
    input wire logic arr_standby,
    input wire logic pump_on,
    input wire logic hv_to_array
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // One wait cycle, then the answer
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence s_back_high;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    // ==============================================================
    // Bus timing and control interlocks
    // ==============================================================
    a_bus_wait_one: assert property ($rose(avs_read || avs_write) |-> s_one_wait)
        else $error("request not answered after one wait cycle");
    a_bus_wait_short: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##1 s_back_high)
        else $error("waitrequest low for more than one cycle");
    a_sel_exclusive: assert property (!(arr_program && arr_erase))
        else $error("program and erase selected together");
    a_hv_has_pump: assert property (hv_to_array |-> pump_on)
        else $error("high voltage to array without charge pump");
    a_hv_rise_sel: assert property ($rose(pump_on) |-> (arr_program || arr_erase))
        else $error("charge pump started with no operation selected");
    a_standby_quiet: assert property (arr_standby |->
        !(pump_on || hv_to_array || arr_program || arr_erase || arr_latch))
        else $error("array control active in standby");
    // Pump may still be on in the first low-power cycle
    a_lowpower_cut: assert property ((wait_mode || stop_mode) |-> ##[1:2] !pump_on)
        else $error("charge pump kept on in low power");
    a_latch_pulse: assert property (arr_latch |=> !arr_latch)
        else $error("latch strobe longer than one cycle");
    a_latch_cause: assert property (arr_latch |->
        (pump_on && arr_program && ($past(avs_write) || $past(avs_write, 2))))
        else $error("latch strobe without a programming write");
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import frpe_pkg::*;
    // ==============================================================
    // Design ports
    // ==============================================================
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [AV_ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [AV_DATA_W-1:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [AV_DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic [7:0] prot_byte = 8'h5A;
    logic [7:0] arr_rdata = 8'h00;
    logic arr_program, arr_erase, arr_mass, arr_latch, arr_standby, pump_on, hv_to_array;
    logic [15:0] arr_addr;
    logic [7:0] arr_wdata;
    int errors = 0;
    int check_count = 0;
    logic [31:0] seed = 32'h000019C3;

    frpe_ctrl uut (.clock, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .wait_mode, .stop_mode, .prot_byte,
        .arr_rdata, .arr_program, .arr_erase, .arr_mass, .arr_addr, .arr_wdata, .arr_latch,
        .arr_standby, .pump_on, .hv_to_array);

    // 125 MHz clock
    always #4 clock = ~clock;

    // ==============================================================
    // Expectations and helpers
    // ==============================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction
    // Mass erase needs the whole array open, page erase only its target
    function automatic logic hv_ok(input logic [7:0] p, input logic [15:0] a, input logic m);
        hv_ok = m ? (p == 8'hFF) : ((p == 8'hFF) || (a < {1'b0, p, 7'h00}));
    endfunction
    function automatic logic [15:0] rnd_addr();
        seed = xs(seed);
        rnd_addr = MAIN_START + (seed[15:0] % 16'h7200);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is sampled low; bounded wait
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h000000, d};
        do
        begin
            @(posedge clock);
            n++;
        end
        while ((avs_waitrequest !== 1'b0) && (n < 40));
        if (n >= 40)
            errors++;
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [15:0] idx, output logic [7:0] q);
        bus(1'b0, idx, 8'h00, q);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    // Select, protect read, row or page write, then high voltage
    // Only this block's indices are touched between steps
    task automatic arm(input logic [7:0] sel, input logic [15:0] a);
        logic [7:0] q;
        wr(IDX_CTRL, sel);
        rd(IDX_PROT, q);
        wr(a, 8'h3C);
        wr(IDX_CTRL, sel | 8'h08);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if ((errors == 0) && (check_count > 0))
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial
    begin
        #(8 * 20000);
        errors++;
        finish_test();
    end

    // ==============================================================
    // Main sequence
    // ==============================================================
    initial
    begin
        logic [7:0] q;
        logic [7:0] d;
        logic [15:0] a;
        logic [15:0] b;
        logic [7:0] pt [6];
        logic [7:0] st [6];
        logic seen;
        pt = '{8'hFF, 8'h00, 8'hFE, 8'h00, 8'hFF, 8'h7F};
        st = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h06, 8'h06};
        repeat (12) @(posedge clock);
        #1;
        check(32'(pump_on), 32'h0);
        @(posedge clock);
        arst_n <= 1'b1;
        // Register map, reset values, refused places
        rd(IDX_CTRL, q);
        check(32'(q), 32'h0);
        rd(IDX_PROT, q);
        check(32'(q), 32'h5A);
        rd(16'h0100, q);
        check(32'(q), 32'h0);
        seed = xs(seed);
        d = seed[7:0];
        arr_rdata <= d;
        a = rnd_addr();
        rd(a, q);
        check(32'(q), 32'(d));
        prot_byte <= 8'hFF;
        // Select interlocks for both selects
        for (int i = 1; i < 3; i++)
        begin
            wr(IDX_CTRL, 8'(i));
            rd(IDX_CTRL, q);
            check(32'(q), 32'(i));
            wr(IDX_CTRL, 8'(3 - i));
            rd(IDX_CTRL, q);
            check(32'(q), 32'h0);
            wr(IDX_CTRL, 8'h03);
            rd(IDX_CTRL, q);
            check(32'(q), 32'h0);
        end
        // High voltage without the protect read is refused
        wr(IDX_CTRL, 8'h01);
        wr(IDX_CTRL, 8'h09);
        rd(IDX_CTRL, q);
        check(32'(q), 32'h01);
        rd(IDX_STAT, q);
        check(32'(q[STAT_REFUSED_BIT]), 32'h1);
        wr(IDX_STAT, 8'h03);
        wr(IDX_CTRL, 8'h00);
        // Page and mass erase against protect settings
        for (int i = 0; i < 6; i++)
        begin
            seed = xs(seed);
            prot_byte <= (i == 3) ? seed[7:0] : pt[i];
            a = (i == 2) ? 16'h7F40 : rnd_addr();
            arm(st[i], a);
            rd(IDX_CTRL, q);
            check(32'(q), 32'(hv_ok(prot_byte, a, st[i][2]) ? (st[i] | 8'h08) : st[i]));
            check(32'({arr_erase, arr_mass}), 32'({1'b1, st[i][2]}));
            if (q[CTRL_HIGH_VOLTAGE_ENABLE_BIT] === 1'b1)
                check(32'(arr_addr), 32'(a & PAGE_MASK));
            wr(IDX_CTRL, 8'h08);
            wr(IDX_CTRL, 8'h00);
            wr(IDX_STAT, 8'h03);
        end
        // Row programming, corner byte at the row end, then a stray row
        prot_byte <= 8'hFF;
        a = rnd_addr() & ROW_MASK;
        arm(8'h01, a);
        tick(1);
        check(32'({pump_on, hv_to_array}), 32'h3);
        for (int k = 0; k < 6; k++)
        begin
            seed = xs(seed);
            b = a | ((k == 5) ? 16'h003F : {10'h000, seed[13:8]});
            d = seed[7:0];
            wr(b, d);
            #1;
            seen = arr_latch;
            @(posedge clock);
            #1;
            seen = seen | arr_latch;
            check(32'(seen), 32'h1);
            check(32'({arr_addr, arr_wdata}), 32'({b, d}));
        end
        wr(a ^ 16'h0040, 8'h11);
        tick(2);
        check(32'({hv_to_array, arr_program}), 32'h0);
        rd(IDX_STAT, q);
        check(32'(q[STAT_ROWFAIL_BIT]), 32'h1);
        wr(IDX_CTRL, 8'h08);
        tick(1);
        check(32'(pump_on), 32'h1);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_STAT, 8'h03);
        rd(IDX_STAT, q);
        check(32'(q[1:0]), 32'h0);
        // Wait mode mid-operation, then stop mode while idle
        arm(8'h01, a);
        @(posedge clock);
        wait_mode <= 1'b1;
        tick(3);
        check(32'({arr_standby, pump_on, arr_program}), 32'h4);
        // Status read while still in wait mode; standby drops on exit
        rd(IDX_STAT, q);
        check(32'(q[STAT_STANDBY_BIT]), 32'h1);
        rd(IDX_CTRL, q);
        check(32'(q[CTRL_HIGH_VOLTAGE_ENABLE_BIT]), 32'h0);
        wait_mode <= 1'b0;
        tick(2);
        check(32'(arr_standby), 32'h0);
        wr(IDX_CTRL, 8'h00);
        @(posedge clock);
        stop_mode <= 1'b1;
        tick(3);
        check(32'(arr_standby), 32'h0);
        @(posedge clock);
        stop_mode <= 1'b0;
        tick(2);
        finish_test();
    end
endmodule

bind frpe_ctrl frpe_ctrl_assertions chk (.clock, .arst_n, .avs_read, .avs_write,
    .avs_waitrequest, .wait_mode, .stop_mode, .arr_program, .arr_erase, .arr_latch,
    .arr_standby, .pump_on, .hv_to_array);
`default_nettype wire

// >>> rtl/frpe_avmm_slave.sv
`timescale 1ns/10ps
`default_nettype none
module frpe_avmm_slave (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Avalon-MM request
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] rd_byte,
    // Avalon-MM answer
    output logic avs_waitrequest,
    output logic [31:0] avs_readdata,
    // Access complete this edge
    output logic rd_done,
    output logic wr_done
);
    import frpe_pkg::*;

    // ==============================================================
    // One wait state per access
    // ==============================================================
    logic wait_q;
    logic [31:0] rdata_q;

    // Drop waitrequest for exactly one cycle after a request is seen
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            wait_q <= 1'b1;
        else
            wait_q <= !((avs_read || avs_write) && wait_q);
    end

    // Read data captured while waiting so it stands at the done edge
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rdata_q <= 32'h0000_0000;
        else if (avs_read && wait_q)
            rdata_q <= {24'h00_0000, rd_byte};
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;
    assign rd_done = avs_read && !wait_q;
    assign wr_done = avs_write && !wait_q;

endmodule
`default_nettype wire

// >>> rtl/frpe_ctrl.sv
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module frpe_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [frpe_pkg::AV_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [frpe_pkg::AV_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [frpe_pkg::AV_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Core low-power modes
    input wire logic wait_mode,
    input wire logic stop_mode,
    // Protect start byte stored in the first array
    input wire logic [7:0] prot_byte,
    // Array read data
    input wire logic [7:0] arr_rdata,
    // Array control
    output logic arr_program,
    output logic arr_erase,
    output logic arr_mass,
    output logic [15:0] arr_addr,
    output logic [7:0] arr_wdata,
    output logic arr_latch,
    output logic arr_standby,
    output logic pump_on,
    output logic hv_to_array
);
    import frpe_pkg::*;

    // ==============================================================
    // Bus decode
    // ==============================================================
    logic rd_done;
    logic wr_done;
    logic [7:0] rd_byte;
    logic [15:0] idx;
    logic [7:0] wbyte;
    logic wr_lane;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_prot;
    logic hit_array;

    // Register index is the word address; only the low lane carries data
    assign idx = avs_address[AV_ADDR_W-1:2];
    assign wbyte = avs_writedata[7:0];
    assign wr_lane = wr_done && avs_byteenable[0];
    assign hit_ctrl = (idx == IDX_CTRL);
    assign hit_stat = (idx == IDX_STAT);
    assign hit_prot = (idx == IDX_PROT);
    assign hit_array = frpe_in_array(idx);

    frpe_avmm_slave u_bus (
        .clock(clock),
        .arst_n(arst_n),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .rd_byte(rd_byte),
        .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata),
        .rd_done(rd_done),
        .wr_done(wr_done)
    );

    // ==============================================================
    // State
    // ==============================================================
    frpe_seq_t seq_q;
    frpe_seq_t seq_d;
    logic pgm_q;
    logic erase_q;
    logic mass_q;
    logic high_voltage_enable_q;
    logic rowfail_q;
    logic refused_q;
    logic standby_q;
    logic [15:0] target_q;
    logic [7:0] wdata_q;
    logic latch_q;
    logic prot_hit;
    logic low_power;
    logic busy;
    logic ctrl_wr;
    logic arr_wr;
    logic hv_req;
    logic hv_ok;
    logic row_bad;
    logic row_ok;

    assign low_power = wait_mode || stop_mode;
    assign busy = pgm_q || erase_q || high_voltage_enable_q;
    assign ctrl_wr = wr_lane && hit_ctrl;
    assign arr_wr = wr_lane && hit_array;

    frpe_prot_decode u_prot (
        .prot_byte(prot_byte),
        .target(target_q),
        .mass(erase_q && mass_q),
        .hit(prot_hit)
    );

    // High voltage only from the armed step and outside protection
    assign hv_req = ctrl_wr && wbyte[CTRL_HIGH_VOLTAGE_ENABLE_BIT] && !high_voltage_enable_q;
    assign hv_ok = (seq_q == FRPE_ARMED) && (pgm_q || erase_q) && !prot_hit;

    // Byte writes during high voltage must stay in the latched row
    assign row_ok = arr_wr && (seq_q == FRPE_HIGH_VOLT) && pgm_q &&
        frpe_same_row(idx, target_q);
    assign row_bad = arr_wr && (seq_q == FRPE_HIGH_VOLT) && pgm_q &&
        !frpe_same_row(idx, target_q);

    // ==============================================================
    // Control register bits
    // ==============================================================
    // Select bits interlock against each other
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pgm_q <= CTRL_RESET[CTRL_PGM_BIT];
            erase_q <= CTRL_RESET[CTRL_ERASE_BIT];
        end
        else if (ctrl_wr && !(wbyte[CTRL_PGM_BIT] && wbyte[CTRL_ERASE_BIT]))
        begin
            pgm_q <= wbyte[CTRL_PGM_BIT] && !erase_q;
            erase_q <= wbyte[CTRL_ERASE_BIT] && !pgm_q;
        end
    end

    // Mass selects the kind of the next erase
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            mass_q <= CTRL_RESET[CTRL_MASS_BIT];
        else if (ctrl_wr)
            mass_q <= wbyte[CTRL_MASS_BIT];
    end

    // High voltage: clear always allowed, set only when sequenced
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            high_voltage_enable_q <= CTRL_RESET[CTRL_HIGH_VOLTAGE_ENABLE_BIT];
        else if (low_power && busy)
            high_voltage_enable_q <= 1'b0;
        else if (ctrl_wr && !wbyte[CTRL_HIGH_VOLTAGE_ENABLE_BIT])
            high_voltage_enable_q <= 1'b0;
        else if (hv_req && hv_ok)
            high_voltage_enable_q <= 1'b1;
    end

    // ==============================================================
    // Sequence tracking
    // ==============================================================
    // Suspension forces the software to restart from the protect read
    always_comb
    begin
        seq_d = seq_q;
        case (seq_q)
            FRPE_IDLE:
            begin
                if (pgm_q || erase_q)
                    seq_d = FRPE_SELECTED;
            end
            FRPE_SELECTED:
            begin
                if (rd_done && hit_prot)
                    seq_d = FRPE_PROT_SEEN;
            end
            FRPE_PROT_SEEN:
            begin
                if (arr_wr)
                    seq_d = FRPE_ARMED;
            end
            FRPE_ARMED:
            begin
                if (hv_req && hv_ok)
                    seq_d = FRPE_HIGH_VOLT;
            end
            FRPE_HIGH_VOLT:
            begin
                if (!high_voltage_enable_q)
                    seq_d = FRPE_SELECTED;
            end
            default:
            begin
                seq_d = FRPE_IDLE;
            end
        endcase
        if (!pgm_q && !erase_q && !high_voltage_enable_q)
            seq_d = FRPE_IDLE;
        else if (low_power)
            seq_d = FRPE_SELECTED;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            seq_q <= FRPE_IDLE;
        else
            seq_q <= seq_d;
    end

    // Target location: row for program, page for erase
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            target_q <= 16'h0000;
        else if (arr_wr && (seq_q == FRPE_PROT_SEEN))
            target_q <= pgm_q ? (idx & ROW_MASK) : (idx & PAGE_MASK);
    end

    // ==============================================================
    // Address and data latch towards the array
    // ==============================================================
    // Latching enabled only while program is selected
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wdata_q <= 8'h00;
            latch_q <= 1'b0;
        end
        else
        begin
            latch_q <= row_ok && !low_power;
            if (row_ok)
                wdata_q <= wbyte;
        end
    end

    // Address presented to the array follows each accepted byte
    logic [15:0] addr_q;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            addr_q <= 16'h0000;
        else if (row_ok)
            addr_q <= idx;
        else if (arr_wr && (seq_q == FRPE_PROT_SEEN))
            addr_q <= pgm_q ? (idx & ROW_MASK) : (idx & PAGE_MASK);
    end

    // ==============================================================
    // Status flags
    // ==============================================================
    // Sticky; write one clears, a same-cycle event wins over the clear
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rowfail_q <= 1'b0;
            refused_q <= 1'b0;
        end
        else
        begin
            if (row_bad)
                rowfail_q <= 1'b1;
            else if (wr_lane && hit_stat && wbyte[STAT_ROWFAIL_BIT])
                rowfail_q <= 1'b0;
            if (hv_req && !hv_ok)
                refused_q <= 1'b1;
            else if (wr_lane && hit_stat && wbyte[STAT_REFUSED_BIT])
                refused_q <= 1'b0;
        end
    end

    // A failed row stays failed until program select is dropped
    logic fail_hold_q;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            fail_hold_q <= 1'b0;
        else if (row_bad)
            fail_hold_q <= 1'b1;
        else if (!pgm_q)
            fail_hold_q <= 1'b0;
    end

    // Standby only when low power catches an operation; read mode untouched
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            standby_q <= 1'b0;
        else if (low_power && busy)
            standby_q <= 1'b1;
        else if (!low_power)
            standby_q <= 1'b0;
    end

    // ==============================================================
    // Array control outputs
    // ==============================================================
    logic prog_o_q;
    logic erase_o_q;
    logic mass_o_q;
    logic pump_q;
    logic hv_arr_q;

    // Every control held inactive in standby
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prog_o_q <= 1'b0;
            erase_o_q <= 1'b0;
            mass_o_q <= 1'b0;
            pump_q <= 1'b0;
            hv_arr_q <= 1'b0;
        end
        else if (low_power)
        begin
            prog_o_q <= 1'b0;
            erase_o_q <= 1'b0;
            mass_o_q <= 1'b0;
            pump_q <= 1'b0;
            hv_arr_q <= 1'b0;
        end
        else
        begin
            // A failed row keeps high voltage off the array cells
            prog_o_q <= pgm_q && !fail_hold_q;
            erase_o_q <= erase_q;
            mass_o_q <= erase_q && mass_q;
            pump_q <= high_voltage_enable_q;
            hv_arr_q <= high_voltage_enable_q && !fail_hold_q;
        end
    end

    // ==============================================================
    // Read mux
    // ==============================================================
    // Array data is passed as stored: erased cells give ones
    always_comb
    begin
        if (hit_ctrl)
            rd_byte = {4'h0, high_voltage_enable_q, mass_q, erase_q, pgm_q};
        else if (hit_stat)
            rd_byte = {4'h0, standby_q, (seq_q == FRPE_ARMED), refused_q, rowfail_q};
        else if (hit_prot)
            rd_byte = prot_byte;
        else if (hit_array)
            rd_byte = arr_rdata;
        else
            rd_byte = 8'h00;
    end

    assign arr_program = prog_o_q;
    assign arr_erase = erase_o_q;
    assign arr_mass = mass_o_q;
    assign arr_addr = addr_q;
    assign arr_wdata = wdata_q;
    assign arr_latch = latch_q;
    assign arr_standby = standby_q;
    assign pump_on = pump_q;
    assign hv_to_array = hv_arr_q;

endmodule
`default_nettype wire

// >>> rtl/frpe_pkg.sv
package frpe_pkg;

    // ==============================================================
    // Bus and map geometry
    // ==============================================================
    localparam int unsigned AV_ADDR_W = 18;
    localparam int unsigned AV_DATA_W = 32;
    localparam int unsigned MAP_ADDR_W = 16;
    localparam int unsigned BYTE_W = 8;

    // Register indices; byte address on the bus is four times these
    localparam logic [15:0] IDX_CTRL = 16'hFE08;
    localparam logic [15:0] IDX_STAT = 16'hFE0A;
    localparam logic [15:0] IDX_PROT = 16'hFF81;

    // ==============================================================
    // Control register fields
    // ==============================================================
    localparam int unsigned CTRL_PGM_BIT = 0;
    localparam int unsigned CTRL_ERASE_BIT = 1;
    localparam int unsigned CTRL_MASS_BIT = 2;
    localparam int unsigned CTRL_HIGH_VOLTAGE_ENABLE_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Status register fields
    localparam int unsigned STAT_ROWFAIL_BIT = 0;
    localparam int unsigned STAT_REFUSED_BIT = 1;
    localparam int unsigned STAT_ARMED_BIT = 2;
    localparam int unsigned STAT_STANDBY_BIT = 3;

    // ==============================================================
    // Array geometry
    // ==============================================================
    localparam logic [15:0] ROW_MASK = 16'hFFC0;
    localparam logic [15:0] PAGE_MASK = 16'hFF80;
    localparam logic [15:0] LOW_START = 16'h0450;
    localparam logic [15:0] LOW_END = 16'h05FF;
    localparam logic [15:0] MAIN_START = 16'h0E00;
    localparam logic [15:0] MAIN_END = 16'h7FFF;
    localparam logic [7:0] PROT_NONE = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Sequence of a program or erase operation
    typedef enum logic [2:0] {
        FRPE_IDLE,
        FRPE_SELECTED,
        FRPE_PROT_SEEN,
        FRPE_ARMED,
        FRPE_HIGH_VOLT
    } frpe_seq_t;

    // Location belongs to the second array
    function automatic logic frpe_in_array(input logic [15:0] a);
        frpe_in_array = ((a >= LOW_START) && (a <= LOW_END)) ||
            ((a >= MAIN_START) && (a <= MAIN_END));
    endfunction

    // Two locations fall in the same 64-byte row
    function automatic logic frpe_same_row(input logic [15:0] a, input logic [15:0] b);
        frpe_same_row = ((a & ROW_MASK) == (b & ROW_MASK));
    endfunction

endpackage

// >>> rtl/frpe_prot_decode.sv
`timescale 1ns/10ps
`default_nettype none
module frpe_prot_decode (
    // Protect start byte and target
    input wire logic [7:0] prot_byte,
    input wire logic [15:0] target,
    input wire logic mass,
    // Result
    output logic hit
);
    import frpe_pkg::*;

    // ==============================================================
    // Protected range test
    // ==============================================================
    logic [15:0] start;

    // Byte holds address bits 14..7 of the start; range ends at top of array
    assign start = {1'b0, prot_byte, 7'h00};

    // Mass erase touches every page, so any protection at all refuses it
    always_comb
    begin
        if (prot_byte == PROT_NONE)
        begin
            hit = 1'b0;
        end
        else if (mass)
        begin
            hit = 1'b1;
        end
        else
        begin
            hit = (target >= start);
        end
    end

endmodule
`default_nettype wire
